/* src/cirqf_defines.vh */
// Constants for the contactless interrupt and error flag block.
// Assumes inclusion by bare name from the design file.
`ifndef CIRQF_DEFINES_VH
`define CIRQF_DEFINES_VH
// Register offsets (byte address = index * 4 since 0xd5 is not word aligned)
`define CIRQF_IDX_MISC 8'hd5
`define CIRQF_IDX_ERR 8'hd6
`define CIRQF_IDX_MIEN 8'hd3
`define CIRQF_IDX_CTRL 8'he0
`define CIRQF_ADDR_MISC 10'h354
`define CIRQF_ADDR_ERR 10'h358
`define CIRQF_ADDR_MIEN 10'h34c
`define CIRQF_ADDR_CTRL 10'h380
// Misc flag bits
`define CIRQF_B_POL 7
`define CIRQF_B_SECURE_SIGNAL_INPUT 4
`define CIRQF_B_MODE 3
`define CIRQF_B_CRC 2
`define CIRQF_B_RFON 1
`define CIRQF_B_RFOFF 0
`define CIRQF_MISC_MASK 8'h1f
// Error flag bits
`define CIRQF_B_WR 7
`define CIRQF_B_TEMP 6
`define CIRQF_B_FIELD_TIMING_ERROR 5
`define CIRQF_B_OVFL 4
`define CIRQF_B_COLL 3
`define CIRQF_B_CHECKSUM_ERROR 2
`define CIRQF_B_PAR 1
`define CIRQF_B_PROT 0
// Control register bits
`define CIRQF_B_RXCRC 0
`define CIRQF_B_SYNC 1
`define CIRQF_B_INIT 2
`define CIRQF_FRAMING_ACTIVE 2'h1
// Speed codes
`define CIRQF_SPEED_106 2'h0
`define CIRQF_RESET_BYTE 8'h00
`endif

/* src/cirqf_flags.v */
// Miscellaneous interrupt flags and command error flags with Avalon-MM slave.
// Assumes event inputs are single-cycle pulses on clk_sys; secure and field
// inputs come from pins and are synchronised here.
//
// Contract
// [RULE_01] Bit 7 write selects clear or set
// [RULE_02] Secure input edges set flag bit 4
// [RULE_03] Mode detection sets flag bit 3
// [RULE_04] Mode detector started only by auto-collision
// [RULE_05] Mode detector restarts after each field reset
// [RULE_06] Checksum completion sets flag bit 2
// [RULE_07] Field appearing sets flag bit 1
// [RULE_08] Field disappearing sets flag bit 0
// [RULE_09] Error register read-only, last command errors
// [RULE_10] FIFO writes in forbidden windows flag violation
// [RULE_11] Overheat sets bit 6, drivers off
// [RULE_12] Field timing error only when framing active
// [RULE_13] Writing full FIFO sets overflow
// [RULE_14] Collision only at 106, cleared at rx start
// [RULE_15] Checksum error when enabled, cleared rx start
// [RULE_16] Parity error at 106, cleared rx start
// [RULE_17] Bad start of frame sets protocol error
// [RULE_18] Byte length violation with sync detect
// [RULE_19] Initiator during auto-collision: protocol error
// [RULE_20] Wrong authenticate byte count: protocol error
// [RULE_21] Two short Miller pauses: protocol error
// [RULE_22] Command start clears errors except overheat
// [RULE_23] Misc flags gated by enable to line
// [RULE_24] Any error sets error summary flag
// [RULE_25] Reads side-effect free, reserved bits zero
//
// Decided for this implementation: the Avalon-MM register port.
`timescale 1ns/1ps
`include "cirqf_defines.vh"

module cirqf_flags (
  // Clock and reset
  input wire clk_sys,
  input wire rst_n,
  // Avalon-MM slave
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  // Pin level inputs
  input wire secure_signal_input,
  input wire field_present,
  input wire temp_overheat,
  // Command events
  input wire cmd_start,
  input wire auto_collision_command,
  input wire authenticate_command,
  input wire checksum_command_active,
  input wire checksum_data_done,
  input wire field_reset,
  input wire mode_identified,
  // Receiver and FIFO events
  input wire rx_start,
  input wire tx_last_sent,
  input wire rx_last_received,
  input wire cpu_fifo_write,
  input wire int_fifo_write,
  input wire fifo_full,
  input wire active_mode,
  input wire [1:0] rx_framing_select,
  input wire [1:0] tx_framing_select,
  input wire [1:0] rx_speed,
  input wire field_timeout,
  input wire bit_collision,
  input wire checksum_fail,
  input wire parity_fail,
  input wire sof_bad,
  input wire byte_length_violation,
  input wire alt_scheme,
  input wire auth_count_wrong,
  input wire miller_short_pauses,
  // Outputs
  output reg irq_line_zero,
  output reg error_summary_flag,
  output reg mode_detector_run,
  output reg antenna_drivers_off
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg sig_prev;
  reg field_prev;
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      sig_prev <= 1'b0;
      field_prev <= 1'b0;
    end else begin
      sync_a <= {temp_overheat, field_present, secure_signal_input};
      sync_b <= sync_a;
      sig_prev <= sync_b[0];
      field_prev <= sync_b[1];
    end
  end
  wire sig_s = sync_b[0];
  wire field_s = sync_b[1];
  wire temp_s = sync_b[2];

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  // Single wait cycle: answer on the second cycle of every request
  wire req = (avs_read | avs_write) & avs_waitrequest;
  wire accept = (avs_read | avs_write) & ~avs_waitrequest;
  wire wr_misc = accept & avs_write & (avs_address == `CIRQF_ADDR_MISC);
  wire wr_mien = accept & avs_write & (avs_address == `CIRQF_ADDR_MIEN);
  wire wr_ctrl = accept & avs_write & (avs_address == `CIRQF_ADDR_CTRL);

  reg [7:0] misc;
  reg [7:0] err;
  reg [4:0] mien;
  reg [2:0] ctrl;
  // Three stages: both sync flops and the history flop must hold pin data
  reg [2:0] sig_armed;
  reg rx_window;

  // ----------------------------------------------------------------
  // Miscellaneous flags
  // ----------------------------------------------------------------
  reg [7:0] next_misc;
  reg [7:0] misc_ev;
  always @* begin
    misc_ev = `CIRQF_RESET_BYTE;
    // [RULE_02] either edge
    misc_ev[`CIRQF_B_SECURE_SIGNAL_INPUT] = sig_armed[2] & (sig_s ^ sig_prev);
    // [RULE_03] mode found
    misc_ev[`CIRQF_B_MODE] = mode_detector_run & mode_identified;
    // [RULE_06] checksum finished
    misc_ev[`CIRQF_B_CRC] = checksum_command_active & checksum_data_done;
    // [RULE_07] field appears
    misc_ev[`CIRQF_B_RFON] = field_s & ~field_prev;
    // [RULE_08] field vanishes
    misc_ev[`CIRQF_B_RFOFF] = ~field_s & field_prev;
    next_misc = misc;
    // [RULE_01] polarity write
    if (wr_misc) begin
      if (avs_writedata[`CIRQF_B_POL])
        next_misc = misc | (avs_writedata[7:0] & `CIRQF_MISC_MASK);
      else
        next_misc = misc & ~(avs_writedata[7:0] & `CIRQF_MISC_MASK);
    end
    // Hardware set wins over a simultaneous software clear
    next_misc = (next_misc | misc_ev) & `CIRQF_MISC_MASK;
  end

  // ----------------------------------------------------------------
  // Error flags
  // ----------------------------------------------------------------
  reg [7:0] next_err;
  reg [7:0] err_ev;
  wire is_106 = (rx_speed == `CIRQF_SPEED_106);
  always @* begin
    err_ev = `CIRQF_RESET_BYTE;
    // [RULE_10] forbidden FIFO write
    err_ev[`CIRQF_B_WR] = cpu_fifo_write & (auto_collision_command | authenticate_command
                          | rx_window);
    // [RULE_11] overheat
    err_ev[`CIRQF_B_TEMP] = temp_s;
    // [RULE_12] framing gated
    err_ev[`CIRQF_B_FIELD_TIMING_ERROR] = active_mode & field_timeout &
      ((rx_framing_select == `CIRQF_FRAMING_ACTIVE) |
       (tx_framing_select == `CIRQF_FRAMING_ACTIVE));
    // [RULE_13] overflow
    err_ev[`CIRQF_B_OVFL] = fifo_full & (cpu_fifo_write | int_fifo_write);
    // [RULE_14] collision at 106 only
    err_ev[`CIRQF_B_COLL] = bit_collision & is_106;
    // [RULE_15] checksum check
    err_ev[`CIRQF_B_CHECKSUM_ERROR] = checksum_fail & ctrl[`CIRQF_B_RXCRC];
    // [RULE_16] parity at 106
    err_ev[`CIRQF_B_PAR] = parity_fail & is_106;
    // [RULE_17] [RULE_18] [RULE_19] [RULE_20] [RULE_21] protocol causes
    err_ev[`CIRQF_B_PROT] = (sof_bad & is_106)
      | (byte_length_violation & ctrl[`CIRQF_B_SYNC] & (alt_scheme | (active_mode & ~is_106)))
      | (auto_collision_command & ctrl[`CIRQF_B_INIT])
      | (authenticate_command & auth_count_wrong)
      | miller_short_pauses;
    next_err = err;
    // [RULE_22] command start clears all but overheat
    if (cmd_start)
      next_err = err & (8'h01 << `CIRQF_B_TEMP);
    // [RULE_14] [RULE_15] [RULE_16] [RULE_17] receiver start clear
    if (rx_start) begin
      next_err[`CIRQF_B_COLL] = 1'b0;
      next_err[`CIRQF_B_CHECKSUM_ERROR] = 1'b0;
      next_err[`CIRQF_B_PAR] = 1'b0;
      next_err[`CIRQF_B_PROT] = 1'b0;
    end
    next_err = next_err | err_ev;
  end

  // ----------------------------------------------------------------
  // Registers and receive window tracking
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      misc <= `CIRQF_RESET_BYTE;
      err <= `CIRQF_RESET_BYTE;
      mien <= 5'h00;
      ctrl <= 3'h0;
      sig_armed <= 3'h0;
      rx_window <= 1'b0;
      mode_detector_run <= 1'b0;
      antenna_drivers_off <= 1'b0;
      irq_line_zero <= 1'b0;
      error_summary_flag <= 1'b0;
    end else begin
      // Edge detector stays quiet until its history is valid
      sig_armed <= {sig_armed[1:0], 1'b1};
      misc <= next_misc;
      // [RULE_09] written only by hardware
      err <= next_err;
      if (wr_mien)
        mien <= avs_writedata[4:0];
      if (wr_ctrl)
        ctrl <= avs_writedata[2:0];
      if (tx_last_sent)
        rx_window <= 1'b1;
      else if (rx_last_received)
        rx_window <= 1'b0;
      // [RULE_04] [RULE_05] start and self-stop
      if (mode_detector_run & mode_identified)
        mode_detector_run <= 1'b0;
      else if ((cmd_start & auto_collision_command) | field_reset)
        mode_detector_run <= 1'b1;
      // [RULE_11] drivers off once overheat is flagged, until reset
      antenna_drivers_off <= next_err[`CIRQF_B_TEMP];
      // [RULE_23] enable gating
      irq_line_zero <= |(next_misc[4:0] & mien);
      // [RULE_24] error summary
      error_summary_flag <= |next_err;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else begin
      avs_waitrequest <= ~(req & avs_waitrequest);
      if (req & avs_waitrequest & avs_read) begin
        // [RULE_25] reads do not disturb flags
        case (avs_address)
          `CIRQF_ADDR_MISC: avs_readdata <= {24'h0, 3'h0, misc[4:0]};
          `CIRQF_ADDR_ERR: avs_readdata <= {24'h0, err};
          `CIRQF_ADDR_MIEN: avs_readdata <= {24'h0, 3'h0, mien};
          `CIRQF_ADDR_CTRL: avs_readdata <= {24'h0, 5'h0, ctrl};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // cirqf_flags

/* test/cirqf_flags_sva.sv */
// Checker for the flag block, bound to its top-level ports.
// Assumes one clock domain with a synchronous active-low reset.
`timescale 1ns/1ps
module cirqf_flags_sva (
  // Clock, reset and bus
  input wire clk_sys,
  input wire rst_n,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  // Events and levels
  input wire temp_overheat,
  input wire cmd_start,
  input wire auto_collision_command,
  input wire field_reset,
  input wire mode_identified,
  input wire cpu_fifo_write,
  input wire fifo_full,
  input wire bit_collision,
  input wire sof_bad,
  input wire [1:0] rx_speed,
  // Outputs
  input wire error_summary_flag,
  input wire mode_detector_run,
  input wire antenna_drivers_off
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  // Sync stages plus flag register fit inside four samples
  sequence s_hot;
    temp_overheat [*4];
  endsequence
  AST_WAIT: assert property (s_req |=> !avs_waitrequest)
    else $error("request not answered after one wait cycle");
  AST_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_UPPER: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_HOT: assert property (s_hot |=> antenna_drivers_off && error_summary_flag)
    else $error("overheat did not switch drivers off");
  AST_COLL: assert property (bit_collision && rx_speed == 2'h0 && !cmd_start
    |=> error_summary_flag)
    else $error("collision did not raise error summary");
  AST_SOF: assert property (sof_bad && rx_speed == 2'h0 && !cmd_start |=> error_summary_flag)
    else $error("bad start of frame did not raise error summary");
  AST_OVFL: assert property (cpu_fifo_write && fifo_full && !cmd_start |=> error_summary_flag)
    else $error("write into full fifo did not raise error summary");
  AST_START: assert property (!mode_detector_run && !auto_collision_command && !field_reset
    |=> !mode_detector_run)
    else $error("mode detector started without command");
  AST_STOP: assert property (mode_detector_run && mode_identified && !auto_collision_command
    && !field_reset |=> !mode_detector_run)
    else $error("mode detector kept running after detection");
  AST_RESTART: assert property (field_reset && !mode_identified |=> mode_detector_run)
    else $error("mode detector not restarted after field reset");
endmodule // cirqf_flags_sva
bind cirqf_flags cirqf_flags_sva u_sva (.*);

/* test/cirqf_host.sv */
// Avalon-MM master standing in for the processor firmware.
// Assumes a slave that lowers waitrequest once per request.
`timescale 1ns/1ps
module cirqf_host (
  // Bus
  input wire clk_sys,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  output logic [9:0] avs_address = 10'h000,
  output logic avs_read = 1'b0,
  output logic avs_write = 1'b0,
  output logic [31:0] avs_writedata = 32'h0
);
  // polarity travels in data
  // Only the bench watchdog ends a wait that never gets an answer
  task xfer(input bit w, input [9:0] a, input [31:0] d, output [31:0] q);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Gap cycle so strobes are never driven twice in one step
    @(posedge clk_sys);
  endtask
endmodule // cirqf_host

/* test/cirqf_flags_test.sv */
// Self-checking bench for the flag block.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "cirqf_defines.vh"
module cirqf_flags_test;
  logic clk_sys = 0, rst_n = 0;
  logic [9:0] avs_address;
  logic avs_read, avs_write, avs_waitrequest, irq_line_zero, error_summary_flag;
  logic mode_detector_run, antenna_drivers_off;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic secure_signal_input = 0, field_present = 0, temp_overheat = 0, cmd_start = 0;
  logic auto_collision_command = 0, authenticate_command = 0, checksum_command_active = 0;
  logic checksum_data_done = 0, field_reset = 0, mode_identified = 0, rx_start = 0;
  logic tx_last_sent = 0, rx_last_received = 0, cpu_fifo_write = 0, int_fifo_write = 0;
  logic fifo_full = 0, active_mode = 0, field_timeout = 0, bit_collision = 0;
  logic checksum_fail = 0, parity_fail = 0, sof_bad = 0, byte_length_violation = 0;
  logic alt_scheme = 0, auth_count_wrong = 0, miller_short_pauses = 0;
  logic [1:0] rx_framing_select = 2'h1, tx_framing_select = 2'h0, rx_speed = 2'h0;
  logic [7:0] exp_m, d;
  logic [7:0] eb [7] = '{8'h20, 8'h08, 8'h04, 8'h02, 8'h01, 8'h01, 8'h10};
  int errors = 0, num_checks = 0;
  always #2 clk_sys = ~clk_sys;
  cirqf_flags dut (.*);
  cirqf_host u_host (.*);
  // ----
  // Helpers
  // ----
  task tally_and_finish;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd(input [9:0] a, input [31:0] e, input string n);
    u_host.xfer(0, a, 0, q);
    chk(n, e, q);
  endtask
  task wr(input [9:0] a, input [31:0] v);
    u_host.xfer(1, a, v, q);
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task clr;
    cmd_start <= 1;
    cyc(1);
    cmd_start <= 0;
    cyc(1);
  endtask
  function logic [7:0] pol(input logic [7:0] e, input logic [7:0] v);
    pol = v[7] ? e | (v & 8'h1f) : e & ~(v & 8'h1f);
  endfunction
  initial begin
    #200000;
    errors++;
    tally_and_finish;
  end
  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(60288));
    cyc(20);
    rst_n <= 1;
    cyc(1);
    rd(`CIRQF_ADDR_MISC, 0, "misc");
    rd(10'h000, 0, "unmapped");
    field_present <= 1;
    secure_signal_input <= 1;
    cyc(5);
    exp_m = 8'h12;
    rd(`CIRQF_ADDR_MISC, exp_m, "pins");
    for (int i = 0; i < 26; i++) begin
      d = i == 0 ? 8'h9f : i == 1 ? 8'h1f : 8'($urandom);
      wr(`CIRQF_ADDR_MISC, d);
      exp_m = pol(exp_m, d);
      rd(`CIRQF_ADDR_MISC, exp_m, "misc_wr");
    end
    field_present <= 0;
    cyc(5);
    exp_m = exp_m | 8'h01;
    rd(`CIRQF_ADDR_MISC, exp_m, "field_off");
    wr(`CIRQF_ADDR_MIEN, 8'h01);
    cyc(1);
    chk("irq_on", 1, irq_line_zero);
    wr(`CIRQF_ADDR_MISC, 8'h01);
    cyc(1);
    chk("irq_off", 0, irq_line_zero);
    wr(`CIRQF_ADDR_ERR, 8'hff);
    rd(`CIRQF_ADDR_ERR, 0, "err_ro");
    wr(`CIRQF_ADDR_CTRL, 8'h05);
    active_mode <= 1;
    auto_collision_command <= 1;
    cmd_start <= 1;
    cyc(1);
    cmd_start <= 0;
    cyc(1);
    chk("run", 1, mode_detector_run);
    mode_identified <= 1;
    auto_collision_command <= 0;
    cyc(1);
    mode_identified <= 0;
    cyc(1);
    chk("stop", 0, mode_detector_run);
    rd(`CIRQF_ADDR_ERR, 8'h01, "initiator");
    rd(`CIRQF_ADDR_MISC, (exp_m & 8'h1e) | 8'h08, "mode");
    wr(`CIRQF_ADDR_CTRL, 8'h01);
    clr;
    for (int i = 0; i < 7; i++) begin
      fifo_full <= i == 6;
      {field_timeout, bit_collision, checksum_fail, parity_fail, sof_bad,
        miller_short_pauses, int_fifo_write} <= 7'h40 >> i;
      cyc(1);
      {field_timeout, bit_collision, checksum_fail, parity_fail, sof_bad,
        miller_short_pauses, int_fifo_write} <= 7'h0;
      rd(`CIRQF_ADDR_ERR, eb[i], "err_set");
      chk("summary", 1, error_summary_flag);
      clr;
      rd(`CIRQF_ADDR_ERR, 0, "err_clr");
    end
    fifo_full <= 0;
    authenticate_command <= 1;
    cpu_fifo_write <= 1;
    bit_collision <= 1;
    cyc(1);
    {authenticate_command, cpu_fifo_write, bit_collision} <= 3'h0;
    rx_start <= 1;
    cyc(1);
    rx_start <= 0;
    rd(`CIRQF_ADDR_ERR, 8'h80, "wr_violation");
    field_reset <= 1;
    checksum_command_active <= 1;
    checksum_data_done <= 1;
    cyc(1);
    {field_reset, checksum_command_active, checksum_data_done} <= 3'h0;
    cyc(1);
    chk("restart", 1, mode_detector_run);
    rd(`CIRQF_ADDR_MISC, (exp_m & 8'h1e) | 8'h0c, "crc_done");
    clr;
    wr(`CIRQF_ADDR_CTRL, 8'h02);
    tx_last_sent <= 1;
    cyc(1);
    {tx_last_sent, cpu_fifo_write, alt_scheme, byte_length_violation} <= 4'h7;
    cyc(1);
    {cpu_fifo_write, alt_scheme, byte_length_violation} <= 3'h0;
    rd(`CIRQF_ADDR_ERR, 8'h81, "window_sync");
    rx_last_received <= 1;
    cyc(1);
    rx_last_received <= 0;
    clr;
    cpu_fifo_write <= 1;
    cyc(1);
    {cpu_fifo_write, authenticate_command, auth_count_wrong, bit_collision, parity_fail} <= 5'h0f;
    rx_speed <= 2'h1;
    cyc(1);
    {authenticate_command, auth_count_wrong, bit_collision, parity_fail} <= 4'h0;
    rd(`CIRQF_ADDR_ERR, 8'h01, "closed");
    repeat (400) begin
      {cmd_start, auto_collision_command, authenticate_command, checksum_command_active,
        checksum_data_done, field_reset, mode_identified, rx_start, tx_last_sent,
        rx_last_received, cpu_fifo_write, int_fifo_write, fifo_full, field_timeout,
        bit_collision, checksum_fail, parity_fail, sof_bad, byte_length_violation,
        alt_scheme, auth_count_wrong, miller_short_pauses, rx_speed, tx_framing_select,
        secure_signal_input} <= 27'($urandom & $urandom);
      cyc(1);
    end
    {cmd_start, auto_collision_command, authenticate_command, checksum_command_active,
      checksum_data_done, field_reset, mode_identified, rx_start, tx_last_sent,
      rx_last_received, cpu_fifo_write, int_fifo_write, fifo_full, field_timeout,
      bit_collision, checksum_fail, parity_fail, sof_bad, byte_length_violation,
      alt_scheme, auth_count_wrong, miller_short_pauses, rx_speed, tx_framing_select,
      secure_signal_input} <= 27'h0;
    cyc(1);
    clr;
    temp_overheat <= 1;
    cyc(5);
    chk("drivers_off", 1, antenna_drivers_off);
    clr;
    rd(`CIRQF_ADDR_ERR, 8'h40, "overheat");
    tally_and_finish;
  end
endmodule // cirqf_flags_test
